/* rtl/sram_ctrl_pkg.sv */
// Package for the asynchronous static memory controller.
// Assumes a 50 MHz system clock; all timing counts but TURN_CYCLES derive from it.
package sram_ctrl_pkg;

  // ==========================================================================
  // Clock and timing constants
  localparam int CLK_PERIOD_PS              = 20000;  // 50 MHz
  localparam int POWER_UP_WAIT_US           = 100;    // Supply stable to first access
  localparam int ADDRESS_ACCESS_TIME_PS     = 15000;  // Slowest grade read access
  localparam int OUTPUT_ENABLE_ACCESS_TIME_PS = 7000;
  localparam int WRITE_END_ADDRESS_SETUP_PS = 10000;  // Also strobe low time
  localparam int WRITE_DATA_SETUP_TIME_PS   = 7000;
  localparam int WRITE_STROBE_FLOAT_DELAY_PS = 7000;
  localparam int DESELECT_STANDBY_DELAY_PS  = 15000;

  // Least times round up to whole cycles, never below one
  function automatic int min_cycles(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int POWER_UP_CYCLES = (POWER_UP_WAIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int READ_CYCLES     = min_cycles(ADDRESS_ACCESS_TIME_PS) + 1;
  localparam int WRITE_CYCLES    =
    min_cycles(WRITE_STROBE_FLOAT_DELAY_PS + WRITE_DATA_SETUP_TIME_PS);
  localparam int TURN_CYCLES     = 1;  // Turnaround load; the turn state lasts two cycles between accesses

  // ==========================================================================
  // Field widths and reset values
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 13;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_POWER_type_unused,
    ST_IDLE, ST_READ, ST_WRITE, ST_TURN
  } state_type;

endpackage

/* rtl/sram_pins_if.sv */
// Interface bundling the memory pin signals between controller and pad stage.
// Assumes one clock domain; the pad stage keeps data out, its enable and data in as separate wires.
interface sram_pins_if;
  logic                                  select_n;
  logic                                  out_en_n;
  logic                                  write_n;
  logic [sram_ctrl_pkg::ADDR_W-1:0]      addr;
  logic [sram_ctrl_pkg::DATA_W-1:0]      dq_out;
  logic                                  dq_oe;
  logic [sram_ctrl_pkg::DATA_W-1:0]      dq_in;

  modport ctrl (output select_n, out_en_n, write_n, addr, dq_out, dq_oe, input dq_in);
  modport pads (input select_n, out_en_n, write_n, addr, dq_out, dq_oe, output dq_in);
endinterface

/* rtl/sram_pad_stage.sv */
// Pad stage: passes pin outputs straight through and synchronises read data back.
// Assumes pins go straight to the memory; input data passes two flip-flops.
module sram_pad_stage (
  // Clock, reset and enable
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic                             ce_i,
  // Controller side
  sram_pins_if.pads                             pins,
  // Memory pins
  output logic                                  select_n_o,
  output logic                                  out_en_n_o,
  output logic                                  write_n_o,
  output logic [sram_ctrl_pkg::ADDR_W-1:0]      addr_o,
  output logic [sram_ctrl_pkg::DATA_W-1:0]      dq_o,
  output logic                                  dq_oe_o,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0] dq_i
);
  logic [sram_ctrl_pkg::DATA_W-1:0] dq_meta;
  logic [sram_ctrl_pkg::DATA_W-1:0] dq_sync;
  logic [sram_ctrl_pkg::DATA_W-1:0] next_dq_meta;
  logic [sram_ctrl_pkg::DATA_W-1:0] next_dq_sync;

  // ==========================================================================
  // Input synchroniser: first stage feeds only the second
  always_comb begin
    next_dq_meta = ce_i ? dq_i : dq_meta;
    next_dq_sync = ce_i ? dq_meta : dq_sync;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_meta <= sram_ctrl_pkg::DATA_RESET;
      dq_sync <= sram_ctrl_pkg::DATA_RESET;
    end else begin
      dq_meta <= next_dq_meta;
      dq_sync <= next_dq_sync;
    end
  end

  // Pin outputs are already registered in the controller; dq_oe is the AND of two registers
  assign select_n_o = pins.select_n;
  assign out_en_n_o = pins.out_en_n;
  assign write_n_o  = pins.write_n;
  assign addr_o     = pins.addr;
  assign dq_o       = pins.dq_out;
  assign dq_oe_o    = pins.dq_oe;
  assign pins.dq_in = dq_sync;
endmodule

/* rtl/sram_ctrl.sv */
// Controller driving an asynchronous 512K x 8 static memory over its pins.
// Assumes the memory is the slowest grade; one request at a time, 50 MHz clock.
module sram_ctrl #(
  parameter int POWER_UP_WAIT = sram_ctrl_pkg::POWER_UP_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic                             ce_i,
  // User request
  input  wire logic                             req_valid_i,
  input  wire logic                             req_write_i,
  input  wire logic [sram_ctrl_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0] req_wdata_i,
  output logic                                  req_ready_o,
  output logic                                  rd_valid_o,
  output logic [sram_ctrl_pkg::DATA_W-1:0]      rd_data_o,
  output logic                                  init_done_o,
  // Memory pins
  output logic                                  select_n_o,
  output logic                                  out_en_n_o,
  output logic                                  write_n_o,
  output logic [sram_ctrl_pkg::ADDR_W-1:0]      addr_o,
  output logic [sram_ctrl_pkg::DATA_W-1:0]      dq_o,
  output logic                                  dq_oe_o,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0] dq_i
);
  localparam int RD_WAIT = sram_ctrl_pkg::READ_CYCLES + 2;  // Two sync stages
  localparam int WR_WAIT = (sram_ctrl_pkg::WRITE_CYCLES <
                            sram_ctrl_pkg::min_cycles(sram_ctrl_pkg::WRITE_END_ADDRESS_SETUP_PS))
                           ? sram_ctrl_pkg::min_cycles(sram_ctrl_pkg::WRITE_END_ADDRESS_SETUP_PS)
                           : sram_ctrl_pkg::WRITE_CYCLES;

  // Refuse a wait that the power-up counter cannot hold
  if (POWER_UP_WAIT < 1 || POWER_UP_WAIT >= (1 << sram_ctrl_pkg::CNT_W)) begin : g_bad_wait
    $error("POWER_UP_WAIT out of counter range");
  end

  sram_pins_if pins ();

  sram_ctrl_pkg::state_type          state;
  sram_ctrl_pkg::state_type          next_state;
  logic [sram_ctrl_pkg::CNT_W-1:0]   cnt;
  logic [sram_ctrl_pkg::CNT_W-1:0]   next_cnt;
  logic                              powered;
  logic                              next_powered;
  logic                              sel_n;
  logic                              next_sel_n;
  logic                              oe_n;
  logic                              next_oe_n;
  logic                              we_n;
  logic                              next_we_n;
  logic                              drive;
  logic                              next_drive;
  logic [sram_ctrl_pkg::ADDR_W-1:0]  addr;
  logic [sram_ctrl_pkg::ADDR_W-1:0]  next_addr;
  logic [sram_ctrl_pkg::DATA_W-1:0]  wdata;
  logic [sram_ctrl_pkg::DATA_W-1:0]  next_wdata;
  logic [sram_ctrl_pkg::DATA_W-1:0]  rdata;
  logic [sram_ctrl_pkg::DATA_W-1:0]  next_rdata;
  logic                              rvalid;
  logic                              next_rvalid;

  // ==========================================================================
  // Sequencer: power-up wait, then one access per request
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_powered = powered;
    next_sel_n   = sel_n;
    next_oe_n    = oe_n;
    next_we_n    = we_n;
    next_drive   = drive;
    next_addr    = addr;
    next_wdata   = wdata;
    next_rdata   = rdata;
    next_rvalid  = 1'b0;
    unique case (state)
      sram_ctrl_pkg::ST_POWER_type_unused: begin
        // Pins idle until the supply settle time expires
        if (cnt == '0) begin
          next_powered = 1'b1;
          next_state   = sram_ctrl_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      sram_ctrl_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          next_addr  = req_addr_i;  // Address set with select, zero setup
          next_wdata = req_wdata_i;
          next_sel_n = 1'b0;        // Wake is immediate on select
          if (req_write_i) begin
            // Output enable stays high so the memory floats its pins
            next_we_n  = 1'b0;
            next_drive = 1'b1;      // Memory is floating, safe to drive
            next_cnt   = sram_ctrl_pkg::CNT_W'(WR_WAIT - 1);
            next_state = sram_ctrl_pkg::ST_WRITE;
          end else begin
            next_oe_n  = 1'b0;      // Strobe stays high on reads
            next_cnt   = sram_ctrl_pkg::CNT_W'(RD_WAIT - 1);
            next_state = sram_ctrl_pkg::ST_READ;
          end
        end
      end
      sram_ctrl_pkg::ST_READ: begin
        // Sample only after access time plus sync latency
        if (cnt == '0) begin
          next_rdata  = pins.dq_in;
          next_rvalid = 1'b1;
          next_oe_n   = 1'b1;
          next_sel_n  = 1'b1;       // Deselect lets the memory go to standby
          next_cnt    = sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::TURN_CYCLES);
          next_state  = sram_ctrl_pkg::ST_TURN;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      sram_ctrl_pkg::ST_WRITE: begin
        // Strobe low time covers setup and float delay
        if (cnt == '0) begin
          next_we_n  = 1'b1;        // Select and strobe rise together
          next_sel_n = 1'b1;
          next_cnt   = sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::TURN_CYCLES);
          next_state = sram_ctrl_pkg::ST_TURN;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      sram_ctrl_pkg::ST_TURN: begin
        // Data and address held one cycle past write end
        next_drive = 1'b0;
        if (cnt == '0) begin
          next_state = sram_ctrl_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = sram_ctrl_pkg::ST_IDLE;
    endcase
    if (!ce_i) begin
      next_state = state; next_cnt = cnt; next_powered = powered;
      next_sel_n = sel_n; next_oe_n = oe_n; next_we_n = we_n;
      next_drive = drive; next_addr = addr; next_wdata = wdata;
      next_rdata = rdata; next_rvalid = rvalid;
    end
  end

  // Registers; power-up counter loaded from the parameter during reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= sram_ctrl_pkg::ST_POWER_type_unused;
      cnt     <= sram_ctrl_pkg::CNT_W'(POWER_UP_WAIT);
      powered <= 1'b0;
      sel_n   <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
      drive   <= 1'b0;
      addr    <= '0;
      wdata   <= sram_ctrl_pkg::DATA_RESET;
      rdata   <= sram_ctrl_pkg::DATA_RESET;
      rvalid  <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      powered <= next_powered;
      sel_n   <= next_sel_n;
      oe_n    <= next_oe_n;
      we_n    <= next_we_n;
      drive   <= next_drive;
      addr    <= next_addr;
      wdata   <= next_wdata;
      rdata   <= next_rdata;
      rvalid  <= next_rvalid;
    end
  end

  // Drive the data pins only when output enable is high
  assign pins.select_n = sel_n;
  assign pins.out_en_n = oe_n;
  assign pins.write_n  = we_n;
  assign pins.addr     = addr;
  assign pins.dq_out   = wdata;
  assign pins.dq_oe    = drive & oe_n;

  sram_pad_stage u_pads (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .pins       (pins),
    .select_n_o (select_n_o),
    .out_en_n_o (out_en_n_o),
    .write_n_o  (write_n_o),
    .addr_o     (addr_o),
    .dq_o       (dq_o),
    .dq_oe_o    (dq_oe_o),
    .dq_i       (dq_i)
  );

  // User side
  assign req_ready_o = (state == sram_ctrl_pkg::ST_IDLE) & ce_i;
  assign rd_valid_o  = rvalid;
  assign rd_data_o   = rdata;
  assign init_done_o = powered;
endmodule

/* tb/sram_ctrl_props.sv */
// Checker of the memory controller's pin timing and request port.
// Assumes one clock domain; bound into sram_ctrl after the module.
module sram_ctrl_checker #(
  parameter int POWER_UP_WAIT = 10
) (
  input wire logic                             clk_i,
  input wire logic                             rst_n_i,
  input wire logic                             ce_i,
  input wire logic                             req_valid_i,
  input wire logic                             req_write_i,
  input wire logic [sram_ctrl_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic                             req_ready_o,
  input wire logic                             rd_valid_o,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] rd_data_o,
  input wire logic                             init_done_o,
  input wire logic                             select_n_o,
  input wire logic                             out_en_n_o,
  input wire logic                             write_n_o,
  input wire logic [sram_ctrl_pkg::ADDR_W-1:0] addr_o,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] dq_o,
  input wire logic                             dq_oe_o,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] dq_i
);
  // ==========================================================================
  // Cycles since reset release, saturating so it never wraps
  int unsigned up_cnt;
  logic        take_rd;
  assign take_rd = req_valid_i && req_ready_o && ce_i && !req_write_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_cnt <= 0;
    else if (up_cnt < 32'h0000_FFFF) up_cnt <= up_cnt + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================================
  // Pin relations
  a_power_up_wait: assert property (!select_n_o |-> up_cnt >= POWER_UP_WAIT)
    else $error("memory selected before power-up wait");
  a_no_ready_early: assert property (!init_done_o |-> !req_ready_o)
    else $error("ready before power-up done");
  a_strobe_high_read: assert property (!out_en_n_o |-> write_n_o)
    else $error("write strobe low during read");
  a_no_contention: assert property (dq_oe_o |-> out_en_n_o)
    else $error("data driven while memory outputs enabled");
  a_data_held_end: assert property (!write_n_o && !select_n_o |=> dq_oe_o && $stable(dq_o))
    else $error("write data not held past write end");
  a_addr_stable_write: assert property (!write_n_o |=> $stable(addr_o))
    else $error("address moved during write");
  a_strobe_shape: assert property ($fell(write_n_o) |-> (out_en_n_o && !select_n_o)
    ##1 (write_n_o && select_n_o))
    else $error("write strobe shape wrong");
  a_read_window: assert property (take_rd |=> (!select_n_o && !out_en_n_o)[*4]
    ##1 (select_n_o && out_en_n_o))
    else $error("read window too short");
  a_read_answer: assert property (take_rd |-> ##5 rd_valid_o)
    else $error("read data late or missing");
  a_single_pulse: assert property (rd_valid_o |=> !rd_valid_o)
    else $error("read valid longer than one cycle");
endmodule

bind sram_ctrl sram_ctrl_checker #(.POWER_UP_WAIT(POWER_UP_WAIT)) u_sram_ctrl_checker (
  .clk_i, .rst_n_i, .ce_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i,
  .req_ready_o, .rd_valid_o, .rd_data_o, .init_done_o, .select_n_o, .out_en_n_o,
  .write_n_o, .addr_o, .dq_o, .dq_oe_o, .dq_i);

/* tb/sram_model.sv */
// Behavioural model of the asynchronous byte-wide static memory.
// Assumes pins come straight from the controller; slow_i picks the slow access.
module sram_model (
  // Control and address
  input  wire logic                             select_n_i,
  input  wire logic                             out_en_n_i,
  input  wire logic                             write_n_i,
  input  wire logic                             slow_i,
  input  wire logic [sram_ctrl_pkg::ADDR_W-1:0] addr_i,
  // Data
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0] dq_i,
  output logic      [sram_ctrl_pkg::DATA_W-1:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [int];
  logic        wr_on;
  logic [7:0]  wd;
  logic [18:0] wa;
  wire  rd_en = !select_n_i && !out_en_n_i && write_n_i;
  initial dq_o = 8'h00;
  initial wr_on = 1'b0;
  // ==========================================================================
  // Write lasts while select and strobe overlap; first rise stores it
  always @(select_n_i or write_n_i or dq_i or addr_i) begin
    if (select_n_i === 1'b0 && write_n_i === 1'b0) begin
      wr_on = 1'b1;
      wd = dq_i;
      wa = addr_i;
    end else if (wr_on) begin
      mem[wa] = wd;
      wr_on = 1'b0;
    end
  end
  // Floating bus shows a changing value so stale data cannot pass
  always @(rd_en or addr_i) begin
    dq_o <= #3 ~dq_o;
    if (rd_en) dq_o <= #(slow_i ? 15 : 5) mem[addr_i];
  end
endmodule

/* tb/test_async_sram_byte_port_timing.sv */
// Testbench of the memory controller against the memory model.
// Assumes a 50 MHz clock and a short power-up wait parameter.
module test_async_sram_byte_port_timing;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PU_WAIT = 10;
  logic        clk_i, rst_n_i, req_valid_i, req_write_i, slow, ce;
  logic        req_ready_o, rd_valid_o, init_done_o, dq_oe_o;
  logic        select_n_o, out_en_n_o, write_n_o;
  logic [18:0] req_addr_i, addr_o;
  logic [7:0]  req_wdata_i, rd_data_o, dq_o, dq_i;
  int          n_errors = 0;
  int          check_count = 0;
  logic [18:0] ta [4] = '{19'h0_0000, 19'h7_FFFF, 19'h2_AAAA, 19'h5_5555};
  logic [7:0]  td [4] = '{8'h3C, 8'hA5, 8'hFF, 8'h00};

  sram_ctrl #(.POWER_UP_WAIT(PU_WAIT)) u_sram_ctrl (
    .clk_i, .rst_n_i, .ce_i(ce), .req_valid_i, .req_write_i, .req_addr_i,
    .req_wdata_i, .req_ready_o, .rd_valid_o, .rd_data_o, .init_done_o, .select_n_o,
    .out_en_n_o, .write_n_o, .addr_o, .dq_o, .dq_oe_o, .dq_i);
  sram_model u_sram_model (.select_n_i(select_n_o), .out_en_n_i(out_en_n_o),
    .write_n_i(write_n_o), .slow_i(slow), .addr_i(addr_o), .dq_i(dq_o), .dq_o(dq_i));

  // ==========================================================================
  // Common tasks
  task automatic results();
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request is held until an edge that sees ready high takes it
  task automatic issue(input logic wr, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 50);
    req_valid_i <= 1'b0;
    chk("request_taken", 1, n < 50);
  endtask
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    issue(1'b1, a, d);
    // Strobe is low only in the cycle right after the taking edge
    #1 chk("write_pins", {4'b0011, a, d},
      {select_n_o, write_n_o, out_en_n_o, dq_oe_o, addr_o, dq_o});
  endtask
  task automatic rd(input logic [18:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    issue(1'b0, a, 8'h00);
    while (rd_valid_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk("read_valid", 1, n < 20);
    chk("read_data", exp, rd_data_o);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_power_up();
    int n;
    logic early;
    n = 0;
    early = 1'b0;
    while (init_done_o !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      if (select_n_o !== 1'b1) early = 1'b1;
      n++;
    end
    chk("power_up_wait", 1, n > PU_WAIT);
    chk("select_during_wait", 0, early);
  endtask
  // Back-to-back writes at both address ends, an overwrite, then reads
  task automatic t_write_read(input logic s);
    slow <= s;
    wr(ta[0], 8'h5A);
    for (int i = 0; i < 4; i++) wr(ta[i], td[i]);
    for (int i = 0; i < 4; i++) rd(ta[i], td[i]);
  endtask
  // Enable low after a write holds the turnaround; a waiting read is not taken
  task automatic t_freeze();
    logic moved;
    moved = 1'b0;
    wr(19'h3_0F0F, 8'h96);
    @(posedge clk_i);
    ce <= 1'b0;
    fork
      rd(19'h3_0F0F, 8'h96);
      begin
        repeat (8) begin
          @(posedge clk_i);
          if (req_ready_o !== 1'b0 || select_n_o !== 1'b1) moved = 1'b1;
        end
        ce <= 1'b1;
      end
    join
    chk("frozen_idle", 0, moved);
  endtask
  // Reset in mid-read releases every pin at once; memory keeps its data
  task automatic t_mid_reset();
    wr(19'h1_2345, 8'hC3);
    issue(1'b0, 19'h1_2345, 8'h00);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    #1 chk("reset_pins", 4'b1110, {select_n_o, out_en_n_o, write_n_o, dq_oe_o});
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_power_up();
    rd(19'h1_2345, 8'hC3);
  endtask
  // ==========================================================================
  // Clock, main sequence and watchdog
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = 19'h0_0000;
    req_wdata_i = 8'h00;
    slow = 1'b0;
    ce = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_power_up();
    t_write_read(1'b0);
    t_write_read(1'b1);
    t_freeze();
    t_mid_reset();
    results();
  end
  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule
